// ### shared/core_mem_consts.svh
// constants for the core-memory cycle control block
`ifndef CORE_MEM_CONSTS_SVH
`define CORE_MEM_CONSTS_SVH

`define WORD_BITS      18
`define ADDR_BITS      16
`define BANK_COUNT     2
`define STACK_COUNT    4
`define TAP_BITS       5

// address fields
`define BANK_HI        15
`define BANK_LO        14
`define STACK_HI       13
`define STACK_LO       12
`define XLINE_HI       11
`define XLINE_LO       6
`define YLINE_HI       5
`define YLINE_LO       0

// delay line timing
`define CLK_PERIOD_NS  50
`define DLY_LINE_NS    1000
`define DLY_LINE_CYC   (`DLY_LINE_NS / `CLK_PERIOD_NS)
`define HALF_CYC       (`DLY_LINE_CYC / 2)

// read half taps, counted from the leading edge of start
`define TAP_RD_ADDR_BEG  5'h00
`define TAP_RD_ADDR_END  5'h05
`define TAP_RD_EN_BEG    5'h01
`define TAP_RD_EN_END    5'h04
`define TAP_RD_RW_BEG    5'h01
`define TAP_RD_RW_END    5'h05
`define TAP_STROBE       5'h03

// write half taps, counted from the trailing edge of start
`define TAP_CLEAR        5'h00
`define TAP_LOAD         5'h01
`define TAP_ARM          5'h02
`define TAP_WR_BEG       5'h03
`define TAP_WR_END       5'h07

`endif

// ### shared/core_mem_pkg.sv
// types for the core-memory cycle control block
package core_mem_pkg;

  typedef enum logic [3:0]
  {
    PH_IDLE  = 4'h1,
    PH_READ  = 4'h2,
    PH_HOLD  = 4'h4,
    PH_WRITE = 4'h8
  } phase_t;

endpackage

// ### shared/bank_if.sv
// connection between the cycle sequencer and one bank's sense-inhibit logic
`timescale 1ns/10ps
`include "core_mem_consts.svh"

interface bank_if
#(
  parameter int WIDTH = `WORD_BITS
)
();
  logic             strobe;
  logic             clear;
  logic             load;
  logic             armN;
  logic             inhEn;
  logic [WIDTH-1:0] sense;
  logic [WIDTH-1:0] loadData;
  logic [WIDTH-1:0] overCurrent;
  logic [WIDTH-1:0] senseData;
  logic [WIDTH-1:0] inhibitDrive;

  modport ctrl
  (
    output strobe, clear, load, armN, inhEn, sense, loadData, overCurrent,
    input  senseData, inhibitDrive
  );

  modport bank
  (
    input  strobe, clear, load, armN, inhEn, sense, loadData, overCurrent,
    output senseData, inhibitDrive
  );
endinterface

// ### verilog/bank_sense_data.sv
// sense data register and inhibit latches of one memory bank
`timescale 1ns/10ps
`include "core_mem_consts.svh"

module bank_sense_data
#(
  parameter int WIDTH = `WORD_BITS
)
(
  input wire logic clk,
  input wire logic rst_n,
  bank_if.bank     bus
);

  logic [WIDTH-1:0] senseData_reg;
  logic [WIDTH-1:0] senseData_next;
  logic [WIDTH-1:0] armLatch_reg;
  logic [WIDTH-1:0] armLatch_next;
  logic [WIDTH-1:0] drive_reg;
  logic [WIDTH-1:0] drive_next;
  logic [WIDTH-1:0] armLow;
  logic [WIDTH-1:0] armHigh;
  logic [WIDTH-1:0] inhGate;

  // ----------------------------------------
  // sense register
  // ----------------------------------------
  assign senseData_next = bus.clear  ? '0 :
                          bus.load   ? bus.loadData :
                          bus.strobe ? (senseData_reg | bus.sense) :
                          senseData_reg;

  // ----------------------------------------
  // inhibit latch and drive
  // ----------------------------------------
  assign armLow  = {WIDTH{~bus.armN}};
  assign armHigh = {WIDTH{bus.armN}};
  assign inhGate = {WIDTH{bus.inhEn}};

  // overcurrent drops the latch and the drive at once
  assign armLatch_next = bus.clear ? '0 : ((armLatch_reg | armLow) & ~bus.overCurrent);
  assign drive_next    = armLatch_reg & ~bus.overCurrent & armHigh
                         & inhGate & ~senseData_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      senseData_reg <= '0;
      armLatch_reg  <= '0;
      drive_reg     <= '0;
    end
    else
    begin
      senseData_reg <= senseData_next;
      armLatch_reg  <= armLatch_next;
      drive_reg     <= drive_next;
    end
  end

  assign bus.senseData    = senseData_reg;
  assign bus.inhibitDrive = drive_reg;

endmodule

// ### verilog/core_memory_cycle_control.sv
// cycle sequencing, address decode and data path for the main core-memory banks
`timescale 1ns/10ps
`include "core_mem_consts.svh"

// Summary of operation
// - strobe with switched core sets that bit of the bank sense register
// - low arming pulse sets inhibit latch; drive only after arm returns high
// - overcurrent resets the inhibit latch and stops inhibit drive at once
// - in write half, inhibit every bit whose sense register bit is zero
// - each cycle is a read half followed by a write half
// - read: word goes to processor data, then rewritten in write half
// - write: read word discarded, new word from processor data stored
// - all control signals decoded from taps of a one microsecond line
// - start rising begins read half, start falling begins write half
// - read pulses need address enable, read enable, rw enable and bank hit
// - strobe enable gated by bank selection into bank 0 or bank 1
// - bank sense registers are ORed before going to processor data
// - address bits split into bank, stack, X line and Y line
// - write half clears the bank sense register, then loads it
module core_memory_cycle_control
#(
  parameter int WIDTH = `WORD_BITS,
  parameter int BANKS = `BANK_COUNT
)
(
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         memStart,
  input  wire logic [`ADDR_BITS-1:0]        address,
  input  wire logic [WIDTH-1:0]             procData,
  input  wire logic [BANKS-1:0][WIDTH-1:0]  senseIn,
  input  wire logic [BANKS-1:0][WIDTH-1:0]  overCurrent,
  output      logic [BANKS-1:0][WIDTH-1:0]  inhibitDrive,
  output      logic [WIDTH-1:0]             memData,
  output      logic [BANKS-1:0]             bankSel,
  output      logic [`STACK_COUNT-1:0]      stackSel,
  output      logic [5:0]                   xLine,
  output      logic [5:0]                   yLine,
  output      logic                         readPulse,
  output      logic                         writePulse,
  output      logic                         busy
);

  localparam logic [`TAP_BITS-1:0] HALF_LAST = `TAP_BITS'(`HALF_CYC - 1);

  // ----------------------------------------
  // state and registers
  // ----------------------------------------
  core_mem_pkg::phase_t     phase_reg;
  core_mem_pkg::phase_t     phase_next;
  logic [`TAP_BITS-1:0]     tap_reg;
  logic [`TAP_BITS-1:0]     tap_next;
  logic                     startPrev_reg;
  logic [`ADDR_BITS-1:0]    addr_reg;
  logic [`ADDR_BITS-1:0]    addr_next;
  logic [BANKS-1:0]         bankSel_reg;
  logic [BANKS-1:0]         bankSel_next;
  logic [`STACK_COUNT-1:0]  stackSel_reg;
  logic [`STACK_COUNT-1:0]  stackSel_next;
  logic [WIDTH-1:0]         memData_reg;
  logic [WIDTH-1:0]         memData_next;
  logic                     readPulse_reg;
  logic                     writePulse_reg;
  logic                     busy_reg;
  logic                     busy_next;

  // ----------------------------------------
  // start edges and phase decode
  // ----------------------------------------
  logic startRise;
  logic inIdle;
  logic inRead;
  logic inWrite;
  logic tapLast;

  assign startRise = memStart & ~startPrev_reg;
  assign inIdle    = (phase_reg == core_mem_pkg::PH_IDLE);
  assign inRead    = (phase_reg == core_mem_pkg::PH_READ);
  assign inWrite   = (phase_reg == core_mem_pkg::PH_WRITE);
  assign tapLast   = (tap_reg == HALF_LAST);

  // busy follows the next phase so it falls with the last write tap
  assign busy_next = (phase_next != core_mem_pkg::PH_IDLE);

  // ----------------------------------------
  // delay line tap decode
  // ----------------------------------------
  logic addrEnRead;
  logic readEn;
  logic rwEnRead;
  logic strobeEn;
  logic clearEn;
  logic loadEn;
  logic armEn;
  logic writeRange;
  logic bankValid;
  logic readPulse_next;
  logic writePulse_next;

  assign addrEnRead = inRead & (tap_reg <= `TAP_RD_ADDR_END);
  assign readEn     = inRead & (tap_reg >= `TAP_RD_EN_BEG)
                      & (tap_reg <= `TAP_RD_EN_END);
  assign rwEnRead   = inRead & (tap_reg >= `TAP_RD_RW_BEG)
                      & (tap_reg <= `TAP_RD_RW_END);
  assign strobeEn   = inRead & (tap_reg == `TAP_STROBE);
  assign clearEn    = inWrite & (tap_reg == `TAP_CLEAR);
  assign loadEn     = inWrite & (tap_reg == `TAP_LOAD);
  assign armEn      = inWrite & (tap_reg == `TAP_ARM);
  assign writeRange = inWrite & (tap_reg >= `TAP_WR_BEG)
                      & (tap_reg <= `TAP_WR_END);

  assign bankValid      = |bankSel_reg;
  assign readPulse_next  = addrEnRead & readEn & rwEnRead & bankValid;
  assign writePulse_next = writeRange & bankValid;

  // ----------------------------------------
  // address capture and decode
  // ----------------------------------------
  logic [`BANK_HI-`BANK_LO:0]   bankIdx;
  logic [`STACK_HI-`STACK_LO:0] stackIdx;
  logic                         capture;

  // a rise seen mid-cycle is dropped, never queued
  assign capture   = inIdle & startRise;
  assign addr_next = capture ? address : addr_reg;
  assign bankIdx   = address[`BANK_HI:`BANK_LO];
  assign stackIdx  = address[`STACK_HI:`STACK_LO];

  // bank codes beyond BANKS leave the select empty, so nothing fires
  always_comb
  begin
    bankSel_next  = bankSel_reg;
    stackSel_next = stackSel_reg;
    if (capture)
    begin
      bankSel_next  = '0;
      stackSel_next = '0;
      for (int b = 0; b < BANKS; b++)
      begin
        if (int'(bankIdx) == b)
        begin
          bankSel_next[b] = 1'b1;
        end
      end
      stackSel_next[stackIdx] = 1'b1;
    end
  end

  // ----------------------------------------
  // cycle sequencer
  // ----------------------------------------
  always_comb
  begin
    phase_next = phase_reg;
    tap_next   = tap_reg;
    unique case (phase_reg)
      core_mem_pkg::PH_IDLE:
      begin
        if (startRise)
        begin
          phase_next = core_mem_pkg::PH_READ;
          tap_next   = '0;
        end
      end
      core_mem_pkg::PH_READ:
      begin
        tap_next = tap_reg + `TAP_BITS'(1);
        if (tapLast)
        begin
          phase_next = core_mem_pkg::PH_HOLD;
          tap_next   = '0;
        end
      end
      core_mem_pkg::PH_HOLD:
      begin
        // the write half waits for start to fall
        if (!memStart)
        begin
          phase_next = core_mem_pkg::PH_WRITE;
          tap_next   = '0;
        end
      end
      core_mem_pkg::PH_WRITE:
      begin
        // the last write tap returns to idle and frees the line
        tap_next = tap_reg + `TAP_BITS'(1);
        if (tapLast)
        begin
          phase_next = core_mem_pkg::PH_IDLE;
          tap_next   = '0;
        end
      end
      default:
      begin
        phase_next = core_mem_pkg::PH_IDLE;
        tap_next   = '0;
      end
    endcase
  end

  // ----------------------------------------
  // bank sense-inhibit logic
  // ----------------------------------------
  bank_if #(.WIDTH(WIDTH)) bankBus [BANKS] ();

  for (genvar b = 0; b < BANKS; b++)
  begin : g_bank
    assign bankBus[b].strobe      = strobeEn & bankSel_reg[b];
    assign bankBus[b].clear       = clearEn & bankSel_reg[b];
    assign bankBus[b].load        = loadEn & bankSel_reg[b];
    assign bankBus[b].armN        = ~(armEn & bankSel_reg[b]);
    assign bankBus[b].inhEn       = writeRange & bankSel_reg[b];
    assign bankBus[b].sense       = senseIn[b];
    assign bankBus[b].loadData    = procData;
    assign bankBus[b].overCurrent = overCurrent[b];
    assign inhibitDrive[b]        = bankBus[b].inhibitDrive;

    bank_sense_data #(.WIDTH(WIDTH)) u_bank_sense_data
    (
      .clk   (clk),
      .rst_n (rst_n),
      .bus   (bankBus[b].bank)
    );
  end

  // ----------------------------------------
  // read data toward processor data register
  // ----------------------------------------
  // the idle bank still adds its last word; the processor owns the transfer
  logic [BANKS-1:0][WIDTH-1:0] bankData;

  for (genvar b = 0; b < BANKS; b++)
  begin : g_data
    assign bankData[b] = bankBus[b].senseData;
  end

  always_comb
  begin
    memData_next = '0;
    for (int b = 0; b < BANKS; b++)
    begin
      memData_next = memData_next | bankData[b];
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_reg     <= core_mem_pkg::PH_IDLE;
      tap_reg       <= '0;
      startPrev_reg <= 1'b0;
      addr_reg      <= '0;
      bankSel_reg   <= '0;
      stackSel_reg  <= '0;
    end
    else
    begin
      phase_reg     <= phase_next;
      tap_reg       <= tap_next;
      startPrev_reg <= memStart;
      addr_reg      <= addr_next;
      bankSel_reg   <= bankSel_next;
      stackSel_reg  <= stackSel_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      memData_reg    <= '0;
      readPulse_reg  <= 1'b0;
      writePulse_reg <= 1'b0;
      busy_reg       <= 1'b0;
    end
    else
    begin
      memData_reg    <= memData_next;
      readPulse_reg  <= readPulse_next;
      writePulse_reg <= writePulse_next;
      busy_reg       <= busy_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign memData    = memData_reg;
  assign bankSel    = bankSel_reg;
  assign stackSel   = stackSel_reg;
  assign xLine      = addr_reg[`XLINE_HI:`XLINE_LO];
  assign yLine      = addr_reg[`YLINE_HI:`YLINE_LO];
  assign readPulse  = readPulse_reg;
  assign writePulse = writePulse_reg;
  assign busy       = busy_reg;

endmodule

// ### testbench/core_memory_cycle_control_chk.sv
// port assertions for the core-memory cycle control block
`timescale 1ns/10ps
module core_memory_cycle_control_chk
#(
  parameter int WIDTH = 18,
  parameter int BANKS = 2
)
(
  input wire logic                        clk,
  input wire logic                        rst_n,
  input wire logic                        memStart,
  input wire logic [15:0]                 address,
  input wire logic [WIDTH-1:0]            procData,
  input wire logic [BANKS-1:0][WIDTH-1:0] senseIn,
  input wire logic [BANKS-1:0][WIDTH-1:0] overCurrent,
  input wire logic [BANKS-1:0][WIDTH-1:0] inhibitDrive,
  input wire logic [WIDTH-1:0]            memData,
  input wire logic [BANKS-1:0]            bankSel,
  input wire logic [3:0]                  stackSel,
  input wire logic [5:0]                  xLine,
  input wire logic [5:0]                  yLine,
  input wire logic                        readPulse,
  input wire logic                        writePulse,
  input wire logic                        busy
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ----------------
  // assertions
  // ----------------
  property p_decode;
    $rose(busy) |-> xLine == $past(address[11:6]) && yLine == $past(address[5:0])
      && stackSel == (4'h1 << $past(address[13:12]));
  endproperty
  a_decode: assert property (p_decode) else $error("address fields wrong");
  property p_bank_gate;
    $rose(busy) |-> bankSel == ($past(address[15]) ? 2'h0 : (2'h1 << $past(address[14])));
  endproperty
  a_bank_gate: assert property (p_bank_gate) else $error("bank select wrong");
  property p_read_pulse;
    $rose(busy) && bankSel != 2'h0 |-> ##2 readPulse [*4] ##1 !readPulse;
  endproperty
  a_read_pulse: assert property (p_read_pulse) else $error("read pulse wrong");
  property p_bad_bank;
    bankSel == 2'h0 |-> !readPulse && !writePulse;
  endproperty
  a_bad_bank: assert property (p_bad_bank) else $error("pulse without bank");
  property p_no_overlap;
    !(readPulse && writePulse);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("read and write overlap");
  property p_write_len;
    $rose(writePulse) |-> writePulse [*5] ##1 !writePulse;
  endproperty
  a_write_len: assert property (p_write_len) else $error("write pulse length wrong");
  property p_inhibit;
    |inhibitDrive |-> writePulse;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibit outside write");
  property p_overcurrent;
    |overCurrent |=> (inhibitDrive & $past(overCurrent)) == '0;
  endproperty
  a_overcurrent: assert property (p_overcurrent) else $error("inhibit not cut");
  property p_busy_min;
    $rose(busy) |-> busy [*8];
  endproperty
  a_busy_min: assert property (p_busy_min) else $error("sequence cut short");
endmodule

bind core_memory_cycle_control core_memory_cycle_control_chk #(.WIDTH(WIDTH), .BANKS(BANKS))
  u_core_memory_cycle_control_chk (.clk, .rst_n, .memStart, .address, .procData, .senseIn,
  .overCurrent, .inhibitDrive, .memData, .bankSel, .stackSel, .xLine, .yLine, .readPulse,
  .writePulse, .busy);

// ### testbench/cpu_timing_model.sv
// processor side: start level, processor data register and memory transfer
`timescale 1ns/10ps
module cpu_timing_model
(
  input  wire logic        clk,
  input  wire logic [17:0] memData,
  output      logic        memStart,
  output      logic [17:0] procData
);
  logic [17:0] lastRead;
  initial
  begin
    memStart = 1'b0;
    procData = 18'h00000;
    lastRead = 18'h00000;
  end
  // start level moves just after an edge
  task setStart(input logic v);
    @(posedge clk);
    memStart <= v;
  endtask
  // set start, take memory at the transfer slot, load data, clear start
  task runCycle(input logic wr, input logic [17:0] wdata, input int hold);
    setStart(1'b1);
    repeat (hold) @(posedge clk);
    lastRead = memData;
    procData <= wr ? wdata : memData;
    memStart <= 1'b0;
  endtask
endmodule

// ### testbench/tb_top.sv
// self-checking bench for the core-memory cycle control block
`timescale 1ns/10ps
module tb_top;
  logic             clk;
  logic             rst_n;
  logic             memStart;
  logic [15:0]      address;
  logic [17:0]      procData;
  logic [1:0][17:0] senseIn;
  logic [1:0][17:0] overCurrent;
  logic [1:0][17:0] inhibitDrive;
  logic [17:0]      memData;
  logic [1:0]       bankSel;
  logic [3:0]       stackSel;
  logic [5:0]       xLine;
  logic [5:0]       yLine;
  logic             readPulse;
  logic             writePulse;
  logic             busy;
  logic [1:0][17:0] bankReg;
  int               errors;
  int               comparisons;

  core_memory_cycle_control u_core_memory_cycle_control (.clk, .rst_n, .memStart, .address, .procData,
    .senseIn, .overCurrent, .inhibitDrive, .memData, .bankSel, .stackSel, .xLine, .yLine, .readPulse,
    .writePulse, .busy);
  cpu_timing_model u_cpu_timing_model (.clk, .memData, .memStart, .procData);

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ----------------
  // helpers
  // ----------------
  task checkWord(input logic [17:0] got, input logic [17:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task checkBit(input logic got, input logic exp);
    checkWord({17'h0, got}, {17'h0, exp});
  endtask
  task waitIdle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 60)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 60)
    begin
      errors++;
      test_done();
    end
  endtask
  // one full cycle; core data on sense lines, memory data and inhibits judged
  task memCycle(input logic [15:0] addr, input logic wr, input logic [17:0] wdata, input logic [17:0] s0,
                input logic [17:0] s1);
    logic [17:0] expRead;
    int          b;
    b = addr[14];
    @(posedge clk);
    address <= addr;
    senseIn <= {s1, s0};
    if (!addr[15])
      bankReg[b] = bankReg[b] | (b ? s1 : s0);
    expRead = bankReg[0] | bankReg[1];
    u_cpu_timing_model.runCycle(wr, wdata, 13);
    checkWord({6'h0, xLine, yLine}, {6'h0, addr[11:0]});
    checkWord({12'h0, bankSel, stackSel}, {12'h0, (addr[15] ? 2'h0 : 2'h1 << addr[14]), 4'h1 << addr[13:12]});
    if (!wr)
      checkWord(u_cpu_timing_model.lastRead, expRead);
    if (!addr[15])
      bankReg[b] = wr ? wdata : expRead;
    repeat (6) @(posedge clk);
    #1;
    checkWord(inhibitDrive[b], addr[15] ? 18'h0 : ~bankReg[b]);
    checkWord(inhibitDrive[b ^ 1], 18'h0);
    checkBit(writePulse, !addr[15]);
    waitIdle();
  endtask
  // ----------------
  // scenarios
  // ----------------
  task t_read_write;
    memCycle(16'h2a95, 1'b0, 18'h0, 18'h2d5a7, 18'h3c3c3);
    memCycle(16'h5123, 1'b1, 18'h0f0f1, 18'h00000, 18'h3ffff);
    memCycle(16'h5123, 1'b0, 18'h0, 18'h00000, 18'h0f0f1);
    $display("test read_write finished");
  endtask
  task t_bad_bank;
    memCycle(16'hb001, 1'b0, 18'h0, 18'h3ffff, 18'h3ffff);
    memCycle(16'hc3ff, 1'b1, 18'h12345, 18'h3ffff, 18'h3ffff);
    $display("test bad_bank finished");
  endtask
  task t_overcurrent;
    @(posedge clk);
    address <= 16'h7fc0;
    u_cpu_timing_model.runCycle(1'b1, 18'h00000, 13);
    bankReg[1] = 18'h0;
    repeat (6) @(posedge clk);
    #1;
    checkWord(inhibitDrive[1], 18'h3ffff);
    @(posedge clk);
    overCurrent[1] <= 18'h00020;
    repeat (2) @(posedge clk);
    #1;
    checkWord(inhibitDrive[1], 18'h3ffdf);
    @(posedge clk);
    overCurrent[1] <= 18'h0;
    waitIdle();
    $display("test overcurrent finished");
  endtask
  task t_early_fall;
    @(posedge clk);
    address <= 16'h0000;
    u_cpu_timing_model.runCycle(1'b1, 18'h15555, 2);
    bankReg[0] = 18'h15555;
    repeat (9) @(posedge clk);
    #1;
    checkBit(writePulse, 1'b0);
    repeat (5) @(posedge clk);
    #1;
    checkBit(writePulse, 1'b1);
    checkWord(inhibitDrive[0], 18'h2aaaa);
    waitIdle();
    $display("test early_fall finished");
  endtask
  task t_rise_busy;
    @(posedge clk);
    address <= 16'h2a95;
    bankReg[0] = bankReg[0] | senseIn[0];
    u_cpu_timing_model.runCycle(1'b0, 18'h0, 13);
    u_cpu_timing_model.setStart(1'b1);
    waitIdle();
    repeat (3) @(posedge clk);
    #1;
    checkBit(busy, 1'b0);
    checkBit(readPulse, 1'b0);
    u_cpu_timing_model.setStart(1'b0);
    $display("test rise_busy finished");
  endtask
  // ----------------
  // run control
  // ----------------
  task test_done;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (2000) @(posedge clk);
    errors++;
    test_done();
  end
  initial
  begin
    rst_n = 1'b0;
    address = 16'h0000;
    senseIn = '0;
    overCurrent = '0;
    bankReg = '0;
    errors = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_read_write();
    t_bad_bank();
    t_overcurrent();
    t_early_fall();
    t_rise_busy();
    t_read_write();
    test_done();
  end
endmodule
